//--- design/can_receive_buffers.sv
`timescale 1ns/1ps
`default_nettype none
module can_receive_buffers
	import can_rx_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register bus
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// frame from the receive engine, one-cycle strobe
	input wire logic msgValid,
	input wire logic msgError,
	input wire logic msgExt,
	input wire logic msgRtr,
	input wire logic [28:0] msgId,
	input wire logic [3:0] msgDlc,
	input wire logic [63:0] msgData,
	input wire logic [2:0] msgFilter,
	// error counting events
	input wire logic recErrInc,
	input wire logic recErrIncBig,
	input wire logic recOk,
	// status
	output logic [1:0] bufferFull,
	output logic errorPassive,
	output logic receiveWarning
);
	typedef struct packed {
		logic [1:0] full;
		logic [1:0][1:0] mode;
		logic [1:0] rtrRo;
		logic dben;
		logic filtHitLow;
		logic [2:0] filtHit1;
		logic [1:0][7:0] sidh;
		logic [1:0][7:0] sidl;
		logic [1:0][7:0] eidh;
		logic [1:0][7:0] eidl;
		logic [1:0][7:0] dlc;
		logic [1:0][7:0][7:0] data;
		logic ovf0;
		logic ovf1;
		logic [7:0] errCnt;
		logic passive;
		logic warn;
		logic awHeld;
		logic wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [7:0] wByte;
		logic wLane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t state;
	state_t next_state;

	// {buffer hit, buffer select, sub index}
	function automatic logic [5:0] addrDecode(input logic [ADDR_W-1:0] a);
		logic [7:0] byteAddr;
		logic [3:0] sub;
		logic hit;
		byteAddr = 8'(a);
		sub = byteAddr[5:2];
		hit = (byteAddr[7] == 1'b0) && (byteAddr[1:0] == 2'b00) && (sub <= REG_DATA7);
		return {hit, byteAddr[6], sub};
	endfunction : addrDecode

	function automatic logic modeAccepts(input logic [1:0] mode, input logic err, input logic ext);
		logic ok;
		ok = 1'b0;
		unique case (mode)
			MODE_ANY: ok = 1'b1;
			MODE_EXT_ONLY: ok = !err && ext;
			MODE_STD_ONLY: ok = !err && !ext;
			MODE_ALL_VALID: ok = !err;
		endcase
		return ok;
	endfunction : modeAccepts

	// acceptance and steering decisions
	logic isLowFilter;
	logic isHighFilter;
	logic ok0;
	logic ok1;
	logic store0;
	logic store1;
	logic overflow0;
	logic overflow1;
	logic redirect;
	assign isLowFilter = msgValid && (msgFilter < 3'h2);
	assign isHighFilter = msgValid && (msgFilter >= 3'h2) && (msgFilter <= LAST_FILTER);
	assign ok0 = modeAccepts(state.mode[0], msgError, msgExt);
	assign ok1 = modeAccepts(state.mode[1], msgError, msgExt);
	assign redirect = isLowFilter && ok0 && state.full[0] && state.dben;
	assign store0 = isLowFilter && ok0 && !state.full[0];
	assign store1 = (redirect || isHighFilter) && ok1 && !state.full[1];
	assign overflow0 = isLowFilter && ok0 && state.full[0] && !state.dben;
	assign overflow1 = (redirect || isHighFilter) && ok1 && state.full[1];

	logic writeNow;
	logic [5:0] wDec;
	logic [5:0] rDec;
	assign writeNow = state.awHeld && state.wHeld && !state.bvalid;
	assign wDec = addrDecode(state.awAddr);
	assign rDec = addrDecode(araddr);

	assign awready = !state.awHeld && !state.bvalid;
	assign wready = !state.wHeld && !state.bvalid;
	assign arready = !state.rvalid;
	assign bvalid = state.bvalid;
	assign bresp = state.bresp;
	assign rvalid = state.rvalid;
	assign rdata = state.rdata;
	assign rresp = state.rresp;
	assign bufferFull = state.full;
	assign errorPassive = state.passive;
	assign receiveWarning = state.warn;

	function automatic logic [7:0] readBufferReg(input state_t s, input logic b, input logic [3:0] sub);
		logic [7:0] v;
		logic [3:0] di;
		v = 8'h00;
		di = sub - REG_DATA0;
		unique case (sub)
			REG_CTRL: begin
				v[CTRL_FULL_BIT] = s.full[b];
				v[CTRL_MODE_LSB +: 2] = s.mode[b];
				v[CTRL_RTR_BIT] = s.rtrRo[b];
				if (!b) begin
					v[CTRL_DBEN_BIT] = s.dben;
					v[CTRL_JUMP_BIT] = s.dben;
					v[0] = s.filtHitLow;
				end else begin
					v[2:0] = s.filtHit1;
				end
			end
			REG_SIDH: v = s.sidh[b];
			REG_SIDL: v = s.sidl[b] & SIDL_MASK;
			REG_EIDH: v = s.eidh[b];
			REG_EIDL: v = s.eidl[b];
			REG_DLC: v = s.dlc[b] & DLC_MASK;
			default: v = s.data[b][di[2:0]];
		endcase
		return v;
	endfunction : readBufferReg

	always_comb begin
		logic b;
		logic [3:0] sub;
		logic [3:0] di;
		logic [7:0] wb;
		logic [7:0] byteAddr;
		logic tb;
		logic [7:0] cnt;
		next_state = state;
		b = wDec[4];
		sub = wDec[3:0];
		di = sub - REG_DATA0;
		wb = state.wByte;
		byteAddr = 8'(state.awAddr);
		tb = 1'b0;
		cnt = state.errCnt;

		// register bus, write channel
		if (awvalid && awready) begin
			next_state.awHeld = 1'b1;
			next_state.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			next_state.wHeld = 1'b1;
			next_state.wByte = wdata[7:0];
			next_state.wLane0 = wstrb[0];
		end
		if (state.bvalid && bready) begin
			next_state.bvalid = 1'b0;
		end
		if (writeNow) begin
			next_state.awHeld = 1'b0;
			next_state.wHeld = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = RESP_OKAY;
			if (wDec[5]) begin
				if (state.wLane0) begin
					unique case (sub)
						REG_CTRL: begin
							if (!wb[CTRL_FULL_BIT]) begin
								next_state.full[b] = 1'b0;
							end
							next_state.mode[b] = wb[CTRL_MODE_LSB +: 2];
							if (!b) begin
								next_state.dben = wb[CTRL_DBEN_BIT];
							end
						end
						REG_SIDH: next_state.sidh[b] = wb;
						REG_SIDL: next_state.sidl[b] = wb & SIDL_MASK;
						REG_EIDH: next_state.eidh[b] = wb;
						REG_EIDL: next_state.eidl[b] = wb;
						REG_DLC: next_state.dlc[b] = wb & DLC_MASK;
						default: next_state.data[b][di[2:0]] = wb;
					endcase
				end
			end else if (byteAddr == OFF_STATUS) begin
				if (state.wLane0 && !wb[STAT_OVF0_BIT]) begin
					next_state.ovf0 = 1'b0;
				end
				if (state.wLane0 && !wb[STAT_OVF1_BIT]) begin
					next_state.ovf1 = 1'b0;
				end
			end else if (byteAddr != OFF_ERRCNT) begin
				next_state.bresp = RESP_SLVERR;
			end
		end

		// register bus, read channel
		if (state.rvalid && rready) begin
			next_state.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_state.rvalid = 1'b1;
			next_state.rresp = RESP_OKAY;
			next_state.rdata = 32'h0000_0000;
			if (rDec[5]) begin
				next_state.rdata[7:0] = readBufferReg(state, rDec[4], rDec[3:0]);
			end else if (8'(araddr) == OFF_STATUS) begin
				next_state.rdata[STAT_OVF0_BIT] = state.ovf0;
				next_state.rdata[STAT_OVF1_BIT] = state.ovf1;
				next_state.rdata[STAT_PASSIVE_BIT] = state.passive;
				next_state.rdata[STAT_WARN_BIT] = state.warn;
			end else if (8'(araddr) == OFF_ERRCNT) begin
				next_state.rdata[7:0] = state.errCnt;
			end else begin
				next_state.rresp = RESP_SLVERR;
			end
		end

		// message store; placed after software writes so a set beats a clear
		if (store0 || store1) begin
			tb = store1;
			next_state.full[tb] = 1'b1;
			next_state.rtrRo[tb] = msgRtr;
			next_state.sidh[tb] = msgExt ? msgId[28:21] : msgId[10:3];
			next_state.sidl[tb] = {msgExt ? msgId[20:18] : msgId[2:0],
				msgExt ? 1'b0 : msgRtr,
				msgExt,
				1'b0,
				msgExt ? msgId[17:16] : 2'b00};
			next_state.eidh[tb] = msgExt ? msgId[15:8] : 8'h00;
			next_state.eidl[tb] = msgExt ? msgId[7:0] : 8'h00;
			next_state.dlc[tb] = {1'b0, msgRtr, 2'b00, msgDlc};
			for (int i = 0; i < 8; i++) begin
				next_state.data[tb][i] = msgData[8*i +: 8];
			end
			if (store0) begin
				next_state.filtHitLow = msgFilter[0];
			end else begin
				next_state.filtHit1 = msgFilter;
			end
		end
		if (overflow0) begin
			next_state.ovf0 = 1'b1;
		end
		if (overflow1) begin
			next_state.ovf1 = 1'b1;
		end

		// receive error counter; no path from here to bus-off
		if (recErrIncBig) begin
			cnt = (cnt > ERR_MAX - ERR_STEP_BIG) ? ERR_MAX : cnt + ERR_STEP_BIG;
		end else if (recErrInc) begin
			cnt = (cnt == ERR_MAX) ? ERR_MAX : cnt + 8'h01;
		end else if (recOk) begin
			if (cnt > PASSIVE_LIMIT) begin
				cnt = ERR_RECOVER;
			end else if (cnt != 8'h00) begin
				cnt = cnt - 8'h01;
			end
		end
		next_state.errCnt = cnt;
		next_state.passive = cnt > PASSIVE_LIMIT;
		next_state.warn = (cnt > WARN_LIMIT) && (cnt <= PASSIVE_LIMIT);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// checks
	property p_store_sets_full;
		@(posedge clk) disable iff (!reset_n)
		store0 |=> state.full[0] && state.filtHitLow == $past(msgFilter[0]);
	endproperty
	a_store_sets_full: assert property (p_store_sets_full) else $error("buffer 0 store lost");

	property p_error_rejected;
		@(posedge clk) disable iff (!reset_n)
		(isLowFilter && msgError && state.mode[0] != MODE_ANY && !state.full[0]) |=> !state.full[0];
	endproperty
	a_error_rejected: assert property (p_error_rejected) else $error("erroneous frame stored");

	property p_redirect;
		@(posedge clk) disable iff (!reset_n)
		(redirect && ok1 && !state.full[1]) |=> state.full[1] && state.filtHit1 == $past(msgFilter);
	endproperty
	a_redirect: assert property (p_redirect) else $error("overflow not redirected");

	property p_no_overwrite;
		@(posedge clk) disable iff (!reset_n)
		(isLowFilter && ok0 && state.full[0] && !state.dben) |=> state.ovf0 && $stable(state.rtrRo[0]);
	endproperty
	a_no_overwrite: assert property (p_no_overwrite) else $error("full buffer 0 disturbed");

	property p_low_code_needs_dben;
		@(posedge clk) disable iff (!reset_n)
		$rose(state.full[1]) && state.filtHit1 < 3'h2 |-> $past(state.dben);
	endproperty
	a_low_code_needs_dben: assert property (p_low_code_needs_dben) else $error("bad filter code");

	property p_separate_flags;
		@(posedge clk) disable iff (!reset_n)
		(store0 && !writeNow) |=> state.full[1] == $past(state.full[1]) && $stable(state.mode[1]);
	endproperty
	a_separate_flags: assert property (p_separate_flags) else $error("buffer 1 flags disturbed");

	property p_srr_ext;
		@(posedge clk) disable iff (!reset_n)
		store0 |=> state.sidl[0][4] == (!state.sidl[0][3] && state.rtrRo[0]);
	endproperty
	a_srr_ext: assert property (p_srr_ext) else $error("substitute bit set on extended");

	property p_passive;
		@(posedge clk) disable iff (!reset_n)
		errorPassive == (state.errCnt > PASSIVE_LIMIT);
	endproperty
	a_passive: assert property (p_passive) else $error("passive state mismatch");

	property p_warn;
		@(posedge clk) disable iff (!reset_n)
		receiveWarning == (state.errCnt > WARN_LIMIT && state.errCnt <= PASSIVE_LIMIT);
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag mismatch");

	property p_bvalid_holds;
		@(posedge clk) disable iff (!reset_n)
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bvalid_holds: assert property (p_bvalid_holds) else $error("write response dropped");
endmodule : can_receive_buffers
`default_nettype wire

//--- design/can_rx_pkg.sv
`default_nettype none
package can_rx_pkg;
	// byte offsets of the map; a buffer block is 14 words
	localparam logic [7:0] OFF_BUF0 = 8'h00;
	localparam logic [7:0] OFF_BUF1 = 8'h40;
	localparam logic [7:0] OFF_STATUS = 8'h80;
	localparam logic [7:0] OFF_ERRCNT = 8'h84;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_SIDH = 4'h1;
	localparam logic [3:0] REG_SIDL = 4'h2;
	localparam logic [3:0] REG_EIDH = 4'h3;
	localparam logic [3:0] REG_EIDL = 4'h4;
	localparam logic [3:0] REG_DLC = 4'h5;
	localparam logic [3:0] REG_DATA0 = 4'h6;
	localparam logic [3:0] REG_DATA7 = 4'hd;
	// control register fields
	localparam int CTRL_FULL_BIT = 7;
	localparam int CTRL_MODE_LSB = 5;
	localparam int CTRL_RTR_BIT = 3;
	localparam int CTRL_DBEN_BIT = 2;
	localparam int CTRL_JUMP_BIT = 1;
	// status register fields
	localparam int STAT_OVF0_BIT = 7;
	localparam int STAT_OVF1_BIT = 6;
	localparam int STAT_PASSIVE_BIT = 3;
	localparam int STAT_WARN_BIT = 1;
	// bits that hold storage; the rest read zero
	localparam logic [7:0] SIDL_MASK = 8'hfb;
	localparam logic [7:0] DLC_MASK = 8'h4f;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ERRCNT_RESET = 8'h00;
	// acceptance modes
	localparam logic [1:0] MODE_ALL_VALID = 2'h0;
	localparam logic [1:0] MODE_STD_ONLY = 2'h1;
	localparam logic [1:0] MODE_EXT_ONLY = 2'h2;
	localparam logic [1:0] MODE_ANY = 2'h3;
	// error counter thresholds
	localparam logic [7:0] WARN_LIMIT = 8'h5f;
	localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;
	localparam logic [7:0] ERR_RECOVER = 8'h77;
	localparam logic [7:0] ERR_MAX = 8'hff;
	localparam logic [7:0] ERR_STEP_BIG = 8'h08;
	localparam logic [2:0] LAST_FILTER = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : can_rx_pkg
`default_nettype wire

//--- tb/can_frame_source.sv
`timescale 1ns/1ps
`default_nettype none
module can_frame_source (
	// clock
	input wire logic clk,
	// finished frame towards the buffers
	output logic msgValid,
	output logic msgError,
	output logic msgExt,
	output logic msgRtr,
	output logic [28:0] msgId,
	output logic [3:0] msgDlc,
	output logic [63:0] msgData,
	output logic [2:0] msgFilter
);
	initial begin
		msgValid = 1'b0;
		{msgError, msgExt, msgRtr, msgId, msgDlc, msgData, msgFilter} = '0;
	end
	// one finished frame, strobed for a single cycle
	task automatic send(input logic ext, input logic rtr, input logic err, input logic [28:0] id,
		input logic [3:0] dlc, input logic [63:0] data, input logic [2:0] filt);
		@(posedge clk);
		msgValid <= 1'b1;
		{msgError, msgExt, msgRtr, msgId, msgDlc, msgData, msgFilter} <= {err, ext, rtr, id, dlc, data, filt};
		@(posedge clk);
		msgValid <= 1'b0;
		// fields are not held after the strobe, so stale values must not be leaned on
		{msgError, msgExt, msgRtr, msgId, msgDlc, msgData, msgFilter} <= ~{err, ext, rtr, id, dlc, data, filt};
	endtask : send
endmodule : can_frame_source
`default_nettype wire

//--- tb/tb_can_receive_buffers.sv
`timescale 1ns/1ps
`default_nettype none
module tb_can_receive_buffers;
	import can_rx_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic recErrInc = 1'b0, recErrIncBig = 1'b0, recOk = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, errorPassive, receiveWarning;
	logic [1:0] bresp, rresp, bufferFull, resp;
	logic [31:0] rdata, rd;
	logic msgValid, msgError, msgExt, msgRtr;
	logic [28:0] msgId;
	logic [3:0] msgDlc;
	logic [63:0] msgData;
	logic [2:0] msgFilter;
	int errCount = 0;
	int nChecks = 0;
	always #10 clk = ~clk;
	can_frame_source can_frame_source_i (.clk(clk), .msgValid(msgValid), .msgError(msgError), .msgExt(msgExt),
		.msgRtr(msgRtr), .msgId(msgId), .msgDlc(msgDlc), .msgData(msgData), .msgFilter(msgFilter));
	can_receive_buffers can_receive_buffers_i (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .msgValid(msgValid), .msgError(msgError),
		.msgExt(msgExt), .msgRtr(msgRtr), .msgId(msgId), .msgDlc(msgDlc), .msgData(msgData),
		.msgFilter(msgFilter), .recErrInc(recErrInc), .recErrIncBig(recErrIncBig), .recOk(recOk),
		.bufferFull(bufferFull), .errorPassive(errorPassive), .receiveWarning(receiveWarning));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// ready is sampled 1 ns after an edge, where it already holds its value for the next edge
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			#1;
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			#1;
			ar = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : axi_read
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		axi_read(a, rd, resp);
		check(rd, exp);
	endtask : rdchk
	task automatic bump(input int kind, input int n);
		repeat (n) begin
			@(posedge clk);
			recOk <= (kind == 0);
			recErrInc <= (kind == 1);
			recErrIncBig <= (kind == 2);
			@(posedge clk);
			{recOk, recErrInc, recErrIncBig} <= 3'b000;
		end
	endtask : bump
	task automatic reset_values;
		rdchk(OFF_BUF0, 32'h0);
		rdchk(OFF_BUF1, 32'h0);
		rdchk(OFF_ERRCNT, 32'h0);
		rdchk(OFF_STATUS, 32'h0);
		axi_read(OFF_BUF0 + 8'h38, rd, resp);
		check(rd, 32'h0);
		check(32'(resp), 32'(RESP_SLVERR));
		axi_write(OFF_BUF1 + 8'h38, 32'hff, resp);
		check(32'(resp), 32'(RESP_SLVERR));
	endtask : reset_values
	task automatic std_to_buf0;
		can_frame_source_i.send(1'b0, 1'b1, 1'b0, 29'h0abcd5a3, 4'h8, 64'h8877665544332211, 3'h1);
		rdchk(OFF_BUF0, 32'h89);
		rdchk(OFF_BUF0 + 8'h04, 32'hb4);
		rdchk(OFF_BUF0 + 8'h08, 32'h70);
		rdchk(OFF_BUF0 + 8'h14, 32'h48);
		for (int m = 0; m < 8; m++) begin
			rdchk(OFF_BUF0 + 8'h18 + 8'(4 * m), 32'(8'h11 * (m + 1)));
		end
		check(32'(bufferFull), 32'h1);
	endtask : std_to_buf0
	task automatic overflow_buf0;
		can_frame_source_i.send(1'b0, 1'b0, 1'b0, 29'h7ff, 4'h1, 64'h0, 3'h0);
		rdchk(OFF_BUF0 + 8'h04, 32'hb4);
		rdchk(OFF_STATUS, 32'h80);
		check(32'(bufferFull), 32'h1);
		axi_write(OFF_STATUS, 32'h0, resp);
		rdchk(OFF_STATUS, 32'h0);
		axi_write(OFF_BUF0, 32'h0, resp);
		rdchk(OFF_BUF0, 32'h09);
		axi_write(OFF_BUF0 + 8'h14, 32'hff, resp);
		rdchk(OFF_BUF0 + 8'h14, 32'h4f);
		// lane 0 strobe off: write is answered but must not land
		wstrb <= 4'he;
		axi_write(OFF_BUF0 + 8'h14, 32'h00, resp);
		wstrb <= 4'hf;
		check(32'(resp), 32'(RESP_OKAY));
		rdchk(OFF_BUF0 + 8'h14, 32'h4f);
	endtask : overflow_buf0
	task automatic double_buffer;
		logic [28:0] id;
		id = 29'h1abcdef5;
		axi_write(OFF_BUF0, 32'h04, resp);
		rdchk(OFF_BUF0, 32'h0f);
		can_frame_source_i.send(1'b0, 1'b0, 1'b0, 29'h123, 4'h1, 64'h5a, 3'h0);
		rdchk(OFF_BUF0, 32'h86);
		can_frame_source_i.send(1'b1, 1'b0, 1'b0, id, 4'h3, 64'hc3, 3'h1);
		rdchk(OFF_BUF1, 32'h81);
		rdchk(OFF_BUF1 + 8'h04, 32'(id[28:21]));
		rdchk(OFF_BUF1 + 8'h08, 32'({id[20:18], 5'b01000} | {6'h0, id[17:16]}));
		rdchk(OFF_BUF1 + 8'h0c, 32'(id[15:8]));
		rdchk(OFF_BUF1 + 8'h10, 32'(id[7:0]));
		rdchk(OFF_BUF1 + 8'h14, 32'h03);
		rdchk(OFF_BUF1 + 8'h18, 32'hc3);
		check(32'(bufferFull), 32'h3);
	endtask : double_buffer
	task automatic mode_table;
		logic [1:0] m;
		logic acc;
		int k;
		axi_write(OFF_BUF0, 32'h0, resp);
		axi_write(OFF_BUF1, 32'h60, resp);
		rdchk(OFF_BUF0, 32'h0);
		for (int i = 0; i < 12; i++) begin
			m = 2'(i / 3);
			k = i % 3;
			acc = (m == MODE_ANY) || (k != 2 && (m == MODE_ALL_VALID || (m == MODE_EXT_ONLY && k == 1)
				|| (m == MODE_STD_ONLY && k == 0)));
			axi_write(OFF_BUF1, 32'({1'b0, m, 5'h0}), resp);
			can_frame_source_i.send(k == 1, 1'b0, k == 2, 29'h123, 4'h2, 64'h0, 3'h4);
			@(negedge clk);
			check(32'(bufferFull), 32'({acc, 1'b0}));
		end
		rdchk(OFF_BUF1, 32'he4);
		axi_write(OFF_BUF1, 32'h0, resp);
		can_frame_source_i.send(1'b0, 1'b0, 1'b0, 29'h123, 4'h2, 64'h0, 3'h6);
		@(negedge clk);
		check(32'(bufferFull), 32'h0);
		can_frame_source_i.send(1'b0, 1'b0, 1'b1, 29'h123, 4'h2, 64'h0, 3'h0);
		@(negedge clk);
		check(32'(bufferFull), 32'h0);
		can_frame_source_i.send(1'b0, 1'b0, 1'b0, 29'h321, 4'h2, 64'h0, 3'h5);
		can_frame_source_i.send(1'b0, 1'b0, 1'b0, 29'h456, 4'h2, 64'h0, 3'h2);
		rdchk(OFF_BUF1, 32'h85);
		rdchk(OFF_BUF1 + 8'h04, 32'h64);
		rdchk(OFF_STATUS, 32'h40);
	endtask : mode_table
	task automatic error_count;
		axi_write(OFF_STATUS, 32'h0, resp);
		bump(2, 12);
		rdchk(OFF_ERRCNT, 32'h60);
		rdchk(OFF_STATUS, 32'h02);
		bump(0, 1);
		rdchk(OFF_STATUS, 32'h00);
		bump(1, 1);
		bump(2, 4);
		@(negedge clk);
		check(32'({errorPassive, receiveWarning}), 32'h2);
		axi_write(OFF_ERRCNT, 32'h0, resp);
		rdchk(OFF_ERRCNT, 32'h80);
		rdchk(OFF_STATUS, 32'h08);
		bump(0, 1);
		rdchk(OFF_ERRCNT, 32'h77);
		rdchk(OFF_STATUS, 32'h02);
		// counter saturates instead of wrapping; nothing beyond passive follows
		bump(2, 18);
		rdchk(OFF_ERRCNT, 32'hff);
		rdchk(OFF_STATUS, 32'h08);
	endtask : error_count
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		reset_values();
		std_to_buf0();
		overflow_buf0();
		double_buffer();
		mode_table();
		error_count();
		final_report();
	end
	// the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		final_report();
	end
endmodule : tb_can_receive_buffers
`default_nettype wire
